// File: core/crmd_top.v
// Decode and execute of control register moves and file loads
`timescale 1ns/1ps
`include "crmd_regs.vh"

module crmd_top #(
	parameter NUM_PORTS = 5,
	parameter FILE_DEPTH = 32
) (
	input wire CORE_CLK_IN,
	input wire RST_IN,
	input wire INSTR_VALID_IN,
	input wire [11:0] INSTR_IN,
	input wire COMP_RESULT_IN,
	input wire [7:0] BUS_ADDR_IN,
	input wire [7:0] BUS_WDATA_IN,
	input wire BUS_WR_IN,
	input wire BUS_RD_IN,
	output reg [7:0] BUS_RDATA_OUT,
	output reg [7:0] ACC_OUT,
	output reg [7:0] MODE_SEL_OUT,
	output reg ZERO_FLAG_OUT,
	output wire [8*NUM_PORTS-1:0] PORT_OE_N_OUT,
	output wire [8*NUM_PORTS-1:0] PORT_PULLUP_OUT,
	output wire [8*NUM_PORTS-1:0] PORT_LEVEL_OUT,
	output wire [8*NUM_PORTS-1:0] PORT_SCHMITT_OUT,
	output reg COMP_ENABLE_OUT,
	output reg COMP_PIN_OUT,
	output reg COMP_PIN_OE_N_OUT
);

// ======================================================================
// Declarations
reg [7:0] file_mem [0:FILE_DEPTH-1];
reg [7:0] comparator_control_reg;
reg [2:0] comp_sync;
reg comp_result;
wire [11:0] op = INSTR_IN;
wire [3:0] port_field = op[3:0];
wire [4:0] file_register_operand = op[4:0];
wire is_ctl;
wire is_sel_reg;
wire is_sel_imm;
wire is_file;
wire port_ok;
wire [3:0] port_rel;
wire [3:0] sel_kind;
wire [3:0] sel_low;
wire comp_hit;
reg sel_ok;
reg [1:0] sel_idx;
wire do_write;
wire do_read;
wire [7:0] ctl_old;
wire [7:0] file_val;
wire [8*NUM_PORTS-1:0] rd_a_bus;
wire [8*NUM_PORTS-1:0] rd_b_bus;
wire [NUM_PORTS-1:0] port_wr;
wire [7:0] bus_port_rel;
wire [1:0] bus_idx;
wire [7:0] bus_port;
reg [7:0] next_rdata;
reg [7:0] next_acc;
reg [7:0] next_sel;
reg next_zero;
integer i;

// ======================================================================
// Decode
assign is_ctl = INSTR_VALID_IN && (op[11:4] == `CRMD_OP_CTL_HI);
assign is_sel_reg = INSTR_VALID_IN && (op == `CRMD_OP_SEL_REG);
assign is_sel_imm = INSTR_VALID_IN && (op[11:4] == `CRMD_OP_SEL_IMM_HI);
assign is_file = INSTR_VALID_IN && (op[11:5] == `CRMD_OP_FILE_HI);
// Fields outside the port range fall through with no access
assign port_ok = (port_field >= `CRMD_PORT_FIRST) && (port_field <= `CRMD_PORT_LAST);
assign port_rel = port_field - `CRMD_PORT_FIRST;
assign sel_kind = MODE_SEL_OUT[7:4];
assign sel_low = MODE_SEL_OUT[3:0];
// Comparator access ignores the upper selector nibble
assign comp_hit = is_ctl && (port_field == `CRMD_PORT_B) && (sel_low == `CRMD_SEL_COMP);

always @* begin
	sel_ok = 1'b1;
	sel_idx = `CRMD_IDX_SCHMITT;
	case (sel_low)
		`CRMD_SEL_DIR: sel_idx = `CRMD_IDX_DIR;
		`CRMD_SEL_PULL: sel_idx = `CRMD_IDX_PULL;
		`CRMD_SEL_LEVEL: sel_idx = `CRMD_IDX_LEVEL;
		`CRMD_SEL_SCHMITT: sel_idx = `CRMD_IDX_SCHMITT;
		default: sel_ok = 1'b0;
	endcase
end

// Upper nibble 0 reads, 1 writes, anything else exchanges
assign do_write = (sel_kind != `CRMD_SEL_KIND_READ);
assign do_read = (sel_kind != `CRMD_SEL_KIND_WRITE);

// ======================================================================
// Port control register sets
assign bus_port_rel = BUS_ADDR_IN - `CRMD_ADDR_PCTL_BASE;
assign bus_idx = bus_port_rel[1:0];
assign bus_port = {2'b00, bus_port_rel[7:2]};

genvar g;
generate
	for (g = 0; g < NUM_PORTS; g = g + 1) begin : gen_port
		localparam [3:0] PORT_IDX = g;
		assign port_wr[g] = is_ctl && port_ok && sel_ok && do_write && !comp_hit
			&& (port_rel == PORT_IDX);
		crmd_port_ctl u_ctl (
			.clk(CORE_CLK_IN),
			.rst(RST_IN),
			.wr_en(port_wr[g]),
			.wr_idx(sel_idx),
			.wr_data(ACC_OUT),
			.rd_idx_a(sel_idx),
			.rd_idx_b(bus_idx),
			.dir(PORT_OE_N_OUT[8*g+7:8*g]),
			.pull(PORT_PULLUP_OUT[8*g+7:8*g]),
			.level(PORT_LEVEL_OUT[8*g+7:8*g]),
			.schmitt(PORT_SCHMITT_OUT[8*g+7:8*g]),
			.rd_data_a(rd_a_bus[8*g+7:8*g]),
			.rd_data_b(rd_b_bus[8*g+7:8*g])
		);
	end
endgenerate

assign ctl_old = comp_hit ? comparator_control_reg : rd_a_bus[8*port_rel[2:0] +: 8];
assign file_val = file_mem[file_register_operand];

// ======================================================================
// Working register, selector and zero flag
always @* begin
	next_acc = ACC_OUT;
	next_sel = MODE_SEL_OUT;
	next_zero = ZERO_FLAG_OUT;
	if (BUS_WR_IN && (BUS_ADDR_IN == `CRMD_ADDR_ACC))
		next_acc = BUS_WDATA_IN;
	if (BUS_WR_IN && (BUS_ADDR_IN == `CRMD_ADDR_SEL))
		next_sel = BUS_WDATA_IN;
	if (BUS_WR_IN && (BUS_ADDR_IN == `CRMD_ADDR_STATUS))
		next_zero = BUS_WDATA_IN[0];
	// The core outranks software when both touch a register in one cycle
	if (comp_hit) begin
		next_acc = comparator_control_reg;
	end else if (is_ctl && port_ok && sel_ok && do_read) begin
		next_acc = ctl_old;
	end else if (is_sel_reg) begin
		next_sel = ACC_OUT;
	end else if (is_sel_imm) begin
		next_sel = {MODE_SEL_OUT[7:4], op[3:0]};
	end else if (is_file) begin
		next_acc = file_val;
		next_zero = (file_val == 8'h00);
	end
end

always @(posedge CORE_CLK_IN) begin
	if (RST_IN) begin
		ACC_OUT <= `CRMD_RST_ACC;
		MODE_SEL_OUT <= `CRMD_RST_SEL;
		ZERO_FLAG_OUT <= 1'b0;
	end else begin
		ACC_OUT <= next_acc;
		MODE_SEL_OUT <= next_sel;
		ZERO_FLAG_OUT <= next_zero;
	end
end

// ======================================================================
// File registers, port data among them
always @(posedge CORE_CLK_IN) begin
	if (RST_IN) begin
		for (i = 0; i < FILE_DEPTH; i = i + 1)
			file_mem[i] <= `CRMD_RST_FILE;
	end else if (BUS_WR_IN && (BUS_ADDR_IN <= `CRMD_ADDR_FILE_LAST)) begin
		file_mem[BUS_ADDR_IN[4:0]] <= BUS_WDATA_IN;
	end
end

// ======================================================================
// Comparator
always @(posedge CORE_CLK_IN) begin
	if (RST_IN) begin
		comparator_control_reg <= `CRMD_RST_COMP;
	end else if (comp_hit) begin
		comparator_control_reg <= ACC_OUT;
	end else if (BUS_WR_IN && (BUS_ADDR_IN == `CRMD_ADDR_COMP)) begin
		comparator_control_reg <= BUS_WDATA_IN;
	end
end

// Analog result is asynchronous; it counts once the last two stages agree
always @(posedge CORE_CLK_IN) begin
	if (RST_IN) begin
		comp_sync <= 3'h0;
		comp_result <= 1'b0;
		COMP_ENABLE_OUT <= 1'b0;
		COMP_PIN_OUT <= 1'b0;
		COMP_PIN_OE_N_OUT <= 1'b1;
	end else begin
		comp_sync <= {comp_sync[1:0], COMP_RESULT_IN};
		if (comp_sync[2] == comp_sync[1])
			comp_result <= comp_sync[2];
		COMP_ENABLE_OUT <= !comparator_control_reg[`CRMD_COMP_EN_N_BIT];
		COMP_PIN_OUT <= comp_result && !comparator_control_reg[`CRMD_COMP_EN_N_BIT];
		COMP_PIN_OE_N_OUT <= comparator_control_reg[`CRMD_COMP_EN_N_BIT]
			|| comparator_control_reg[`CRMD_COMP_OE_N_BIT];
	end
end

// ======================================================================
// Software read port
always @* begin
	next_rdata = 8'h00;
	if (BUS_ADDR_IN <= `CRMD_ADDR_FILE_LAST)
		next_rdata = file_mem[BUS_ADDR_IN[4:0]];
	else if (BUS_ADDR_IN == `CRMD_ADDR_ACC)
		next_rdata = ACC_OUT;
	else if (BUS_ADDR_IN == `CRMD_ADDR_SEL)
		next_rdata = MODE_SEL_OUT;
	else if (BUS_ADDR_IN == `CRMD_ADDR_STATUS)
		next_rdata = {7'h00, ZERO_FLAG_OUT};
	else if (BUS_ADDR_IN == `CRMD_ADDR_COMP)
		next_rdata = comparator_control_reg;
	else if (BUS_ADDR_IN == `CRMD_ADDR_COMP_RES)
		next_rdata = {7'h00, comp_result};
	else if ((BUS_ADDR_IN >= `CRMD_ADDR_PCTL_BASE) && (BUS_ADDR_IN <= `CRMD_ADDR_PCTL_LAST))
		next_rdata = rd_b_bus[8*bus_port[2:0] +: 8];
end

always @(posedge CORE_CLK_IN) begin
	if (RST_IN)
		BUS_RDATA_OUT <= 8'h00;
	else if (BUS_RD_IN)
		BUS_RDATA_OUT <= next_rdata;
	else
		BUS_RDATA_OUT <= 8'h00;
end

endmodule

// File: core/crmd_regs.vh
// Constants for the control register move decoder
//
// How it works
// - Opcode 0000 0000 ffff, f 5-9 selects ports A-E
// - Selector picks target register and access kind
// - Exchange writes W, returns old register value
// - Each port has direction, pullup, level, Schmitt
// - Port data reached only through file addressing
// - Selector 1Fh reaches data direction registers
// - Direction bit one is input, zero drives
// - Low nibble 8 on port B swaps comparator
// - Comparator 00h enables comparator and output pin
// - Immediate selector load changes low nibble only
// - File load copies register into W, one cycle
// - File load sets zero flag on 00h
// - Register selector load copies W, keeps W
`ifndef CRMD_REGS_VH
`define CRMD_REGS_VH

// ======================================================================
// Instruction encodings
`define CRMD_OP_CTL_HI 8'h00
`define CRMD_OP_SEL_REG 12'h043
`define CRMD_OP_SEL_IMM_HI 8'h05
`define CRMD_OP_FILE_HI 7'h10
`define CRMD_PORT_FIRST 4'h5
`define CRMD_PORT_LAST 4'h9
`define CRMD_PORT_B 4'h6

// ======================================================================
// Selector fields
`define CRMD_SEL_KIND_READ 4'h0
`define CRMD_SEL_KIND_WRITE 4'h1
`define CRMD_SEL_DIR 4'hF
`define CRMD_SEL_PULL 4'hE
`define CRMD_SEL_LEVEL 4'hD
`define CRMD_SEL_SCHMITT 4'hC
`define CRMD_SEL_COMP 4'h8
`define CRMD_IDX_DIR 2'h0
`define CRMD_IDX_PULL 2'h1
`define CRMD_IDX_LEVEL 2'h2
`define CRMD_IDX_SCHMITT 2'h3

// ======================================================================
// Comparator control fields
`define CRMD_COMP_EN_N_BIT 7
`define CRMD_COMP_OE_N_BIT 6

// ======================================================================
// Reset values
`define CRMD_RST_ACC 8'h00
`define CRMD_RST_SEL 8'h1F
`define CRMD_RST_DIR 8'hFF
`define CRMD_RST_PULL 8'hFF
`define CRMD_RST_LEVEL 8'hFF
`define CRMD_RST_SCHMITT 8'hFF
`define CRMD_RST_COMP 8'hFF
`define CRMD_RST_FILE 8'h00

// ======================================================================
// Software register map
`define CRMD_ADDR_FILE_LAST 8'h1F
`define CRMD_ADDR_ACC 8'h20
`define CRMD_ADDR_SEL 8'h21
`define CRMD_ADDR_STATUS 8'h22
`define CRMD_ADDR_COMP 8'h23
`define CRMD_ADDR_COMP_RES 8'h24
`define CRMD_ADDR_PCTL_BASE 8'h40
`define CRMD_ADDR_PCTL_LAST 8'h53

`endif

// File: core/crmd_port_ctl.v
// Control register set of one port
`timescale 1ns/1ps
`include "crmd_regs.vh"

module crmd_port_ctl (
	input wire clk,
	input wire rst,
	input wire wr_en,
	input wire [1:0] wr_idx,
	input wire [7:0] wr_data,
	input wire [1:0] rd_idx_a,
	input wire [1:0] rd_idx_b,
	output reg [7:0] dir,
	output reg [7:0] pull,
	output reg [7:0] level,
	output reg [7:0] schmitt,
	output reg [7:0] rd_data_a,
	output reg [7:0] rd_data_b
);

// ======================================================================
// Storage
always @(posedge clk) begin
	if (rst) begin
		dir <= `CRMD_RST_DIR;
		pull <= `CRMD_RST_PULL;
		level <= `CRMD_RST_LEVEL;
		schmitt <= `CRMD_RST_SCHMITT;
	end else if (wr_en) begin
		case (wr_idx)
			`CRMD_IDX_DIR: dir <= wr_data;
			`CRMD_IDX_PULL: pull <= wr_data;
			`CRMD_IDX_LEVEL: level <= wr_data;
			default: schmitt <= wr_data;
		endcase
	end
end

// ======================================================================
// Read selection
always @* begin
	case (rd_idx_a)
		`CRMD_IDX_DIR: rd_data_a = dir;
		`CRMD_IDX_PULL: rd_data_a = pull;
		`CRMD_IDX_LEVEL: rd_data_a = level;
		default: rd_data_a = schmitt;
	endcase
	case (rd_idx_b)
		`CRMD_IDX_DIR: rd_data_b = dir;
		`CRMD_IDX_PULL: rd_data_b = pull;
		`CRMD_IDX_LEVEL: rd_data_b = level;
		default: rd_data_b = schmitt;
	endcase
end

endmodule

// File: dv/crmd_chk.sv
// Assertion checker for the control register move decoder
`timescale 1ns/1ps
module crmd_chk #(
	parameter NUM_PORTS = 5
) (
	input logic CORE_CLK_IN,
	input logic RST_IN,
	input logic INSTR_VALID_IN,
	input logic [11:0] INSTR_IN,
	input logic BUS_WR_IN,
	input logic BUS_RD_IN,
	input logic [7:0] BUS_RDATA_OUT,
	input logic [7:0] ACC_OUT,
	input logic [7:0] MODE_SEL_OUT,
	input logic ZERO_FLAG_OUT,
	input logic [8*NUM_PORTS-1:0] PORT_OE_N_OUT,
	input logic [8*NUM_PORTS-1:0] PORT_PULLUP_OUT,
	input logic COMP_ENABLE_OUT,
	input logic COMP_PIN_OE_N_OUT
);
	// ======================================================================
	// Properties
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	// Bus writes are left out, since a bus write to W would also change it
	wire ctl_op = INSTR_VALID_IN && INSTR_IN[11:4] == 8'h00 && !BUS_WR_IN;
	wire port_b = ctl_op && INSTR_IN[3:0] == 4'h6;
	a_sel_copy: assert property (INSTR_VALID_IN && INSTR_IN == 12'h043 && !BUS_WR_IN |=>
		MODE_SEL_OUT == $past(ACC_OUT) && $stable(ACC_OUT)) else $error("selector copy wrong");
	a_sel_nibble: assert property (INSTR_VALID_IN && INSTR_IN[11:4] == 8'h05 |=>
		$stable(MODE_SEL_OUT[7:4]) && MODE_SEL_OUT[3:0] == $past(INSTR_IN[3:0])) else $error("nibble load wrong");
	a_zero_load: assert property (INSTR_VALID_IN && INSTR_IN[11:5] == 7'h10 |=>
		ZERO_FLAG_OUT == (ACC_OUT == 8'h00)) else $error("zero flag wrong");
	a_ctl_flags: assert property (ctl_op |=> $stable(ZERO_FLAG_OUT)) else $error("flag changed");
	a_bad_port: assert property (ctl_op && (INSTR_IN[3:0] < 4'h5 || INSTR_IN[3:0] > 4'h9) |=>
		$stable(ACC_OUT) && $stable(PORT_OE_N_OUT) && $stable(PORT_PULLUP_OUT)) else $error("bad port acted");
	a_dir_write: assert property (port_b && MODE_SEL_OUT == 8'h1F |=>
		PORT_OE_N_OUT[15:8] == $past(ACC_OUT) && $stable(ACC_OUT)) else $error("direction write wrong");
	a_swap_dir: assert property (port_b && MODE_SEL_OUT == 8'h2F |=>
		ACC_OUT == $past(PORT_OE_N_OUT[15:8]) && PORT_OE_N_OUT[15:8] == $past(ACC_OUT)) else $error("swap wrong");
	a_comp_on: assert property (port_b && MODE_SEL_OUT[3:0] == 4'h8 && ACC_OUT == 8'h00 |->
		##2 COMP_ENABLE_OUT && !COMP_PIN_OE_N_OUT) else $error("comparator not on");
	a_other_port: assert property (port_b |=>
		$stable(PORT_OE_N_OUT[7:0]) && $stable(PORT_PULLUP_OUT[7:0])) else $error("port A touched");
	a_rdata_idle: assert property (!BUS_RD_IN |=> BUS_RDATA_OUT == 8'h00) else $error("read data not idle");
endmodule

// File: dv/testbench.sv
// Self-checking testbench for the control register move decoder
`timescale 1ns/1ps
module testbench;
	logic clk, rst, instr_valid, bus_wr, bus_rd, zero, comp_en, comp_oe_n, comp_res, comp_pin;
	logic [11:0] instr;
	logic [7:0] bus_addr, bus_wdata, rdata, acc, mode_sel;
	logic [39:0] oe_n, pull, lvl, sch;
	logic [36:0] rows [14];
	int n_errors = 0;
	int num_checks = 0;
	crmd_top dut (.CORE_CLK_IN(clk), .RST_IN(rst), .INSTR_VALID_IN(instr_valid), .INSTR_IN(instr),
		.COMP_RESULT_IN(comp_res), .BUS_ADDR_IN(bus_addr), .BUS_WDATA_IN(bus_wdata), .BUS_WR_IN(bus_wr),
		.BUS_RD_IN(bus_rd), .BUS_RDATA_OUT(rdata), .ACC_OUT(acc), .MODE_SEL_OUT(mode_sel),
		.ZERO_FLAG_OUT(zero), .PORT_OE_N_OUT(oe_n), .PORT_PULLUP_OUT(pull), .PORT_LEVEL_OUT(lvl),
		.PORT_SCHMITT_OUT(sch), .COMP_ENABLE_OUT(comp_en), .COMP_PIN_OUT(comp_pin),
		.COMP_PIN_OE_N_OUT(comp_oe_n));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ======================================================================
	// Tasks
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test;
		if (n_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic ex(input logic [11:0] op);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= op;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(negedge clk);
		chk("rdata", rdata, e);
	endtask
	// ======================================================================
	// Watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		finish_test();
	end
	// ======================================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 12'h000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		comp_res = 1'b0;
		// Row: opcode, then W, selector, zero flag and port A pullups after it
		rows = '{{12'h204, 8'hA5, 8'h1F, 1'b0, 8'hFF}, {12'h203, 8'h00, 8'h1F, 1'b1, 8'hFF},
			{12'h211, 8'h2E, 8'h1F, 1'b0, 8'hFF}, {12'h043, 8'h2E, 8'h2E, 1'b0, 8'hFF},
			{12'h005, 8'hFF, 8'h2E, 1'b0, 8'h2E}, {12'h210, 8'h0E, 8'h2E, 1'b0, 8'h2E},
			{12'h043, 8'h0E, 8'h0E, 1'b0, 8'h2E}, {12'h005, 8'h2E, 8'h0E, 1'b0, 8'h2E},
			{12'h203, 8'h00, 8'h0E, 1'b1, 8'h2E}, {12'h05A, 8'h00, 8'h0A, 1'b1, 8'h2E},
			{12'h005, 8'h00, 8'h0A, 1'b1, 8'h2E}, {12'h00A, 8'h00, 8'h0A, 1'b1, 8'h2E},
			{12'h05E, 8'h00, 8'h0E, 1'b1, 8'h2E}, {12'h004, 8'h00, 8'h0E, 1'b1, 8'h2E}};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("sel", mode_sel, 8'h1F);
		chk("comp_oe_n", comp_oe_n, 8'h01);
		wr(8'h03, 8'h00);
		wr(8'h04, 8'hA5);
		wr(8'h10, 8'h0E);
		wr(8'h11, 8'h2E);
		@(posedge clk);
		// Back to back: each row's result is read while the next row is taken
		for (int i = 0; i <= 14; i++) begin
			if (i < 14) begin
				instr_valid <= 1'b1;
				instr <= rows[i][36:25];
			end else begin
				instr_valid <= 1'b0;
			end
			@(negedge clk);
			if (i > 0) begin
				chk("acc", acc, rows[i-1][24:17]);
				chk("sel", mode_sel, rows[i-1][16:9]);
				chk("zero", zero, rows[i-1][8]);
				chk("pull_a", pull[7:0], rows[i-1][7:0]);
			end
			@(posedge clk);
		end
		// ======================================================================
		// Direction registers, boundary port and exchange
		wr(8'h20, 8'h1F);
		ex(12'h043);
		wr(8'h20, 8'h3F);
		ex(12'h006);
		chk("dir_b", oe_n[15:8], 8'h3F);
		chk("acc", acc, 8'h3F);
		wr(8'h20, 8'h55);
		ex(12'h009);
		chk("dir_e", oe_n[39:32], 8'h55);
		wr(8'h20, 8'h2F);
		ex(12'h043);
		ex(12'h006);
		chk("dir_b", oe_n[15:8], 8'h2F);
		chk("acc", acc, 8'h3F);
		// ======================================================================
		// Comparator swap; upper selector nibble 1 would mean write elsewhere
		wr(8'h21, 8'h1F);
		ex(12'h058);
		wr(8'h20, 8'h00);
		ex(12'h006);
		chk("acc", acc, 8'hFF);
		chk("dir_b", oe_n[15:8], 8'h2F);
		@(negedge clk);
		chk("comp_en", comp_en, 8'h01);
		chk("comp_oe_n", comp_oe_n, 8'h00);
		rd(8'h04, 8'hA5);
		rd(8'h20, 8'hFF);
		rd(8'h30, 8'h00);
		// Level and Schmitt registers, checked on the pins and by readback
		wr(8'h21, 8'h1D);
		wr(8'h20, 8'h5A);
		ex(12'h005);
		chk("level_a", lvl[7:0], 8'h5A);
		rd(8'h42, 8'h5A);
		wr(8'h21, 8'h1C);
		ex(12'h006);
		chk("schmitt_b", sch[15:8], 8'h5A);
		rd(8'h47, 8'h5A);
		// Result needs three sync stages, the result flop and the pin flop
		@(posedge clk);
		comp_res <= 1'b1;
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk("comp_pin", comp_pin, 8'h01);
		rd(8'h24, 8'h01);
		// ======================================================================
		// Second reset in mid-run
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("sel", mode_sel, 8'h1F);
		chk("dir_b", oe_n[15:8], 8'hFF);
		chk("comp_pin", comp_pin, 8'h00);
		finish_test();
	end
endmodule

bind crmd_top crmd_chk #(.NUM_PORTS(NUM_PORTS)) chk_i (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN),
	.INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_IN(INSTR_IN), .BUS_WR_IN(BUS_WR_IN), .BUS_RD_IN(BUS_RD_IN),
	.BUS_RDATA_OUT(BUS_RDATA_OUT), .ACC_OUT(ACC_OUT), .MODE_SEL_OUT(MODE_SEL_OUT),
	.ZERO_FLAG_OUT(ZERO_FLAG_OUT), .PORT_OE_N_OUT(PORT_OE_N_OUT), .PORT_PULLUP_OUT(PORT_PULLUP_OUT),
	.COMP_ENABLE_OUT(COMP_ENABLE_OUT), .COMP_PIN_OE_N_OUT(COMP_PIN_OE_N_OUT));
